// [core/fsc_pkg.sv]
package fsc_pkg;

    // ==========================================================
    // frame layout
    localparam int unsigned DA_BYTES = 6;
    localparam logic [3:0] HDR_LAST = 4'hB;
    localparam logic [15:0] SECTAG_ETYPE = 16'h88E5;
    // port-authentication / key-agreement frames, to be programmed into an ethertype criterion
    localparam logic [15:0] PORT_AUTH_ETYPE = 16'h888E;
    localparam logic [2:0] SECTAG_LAST = 3'h5;
    localparam logic [7:0] SL_LIMIT = 8'h30;

    // ==========================================================
    // security tag control byte fields
    localparam int unsigned TCI_V = 7;
    localparam int unsigned TCI_ES = 6;
    localparam int unsigned TCI_SC = 5;
    localparam int unsigned TCI_SCB = 4;
    localparam int unsigned TCI_E = 3;
    localparam int unsigned TCI_C = 2;

    // tag check enable bit positions
    localparam int unsigned CHK_V = 0;
    localparam int unsigned CHK_CE = 1;
    localparam int unsigned CHK_SCES = 2;
    localparam int unsigned CHK_SCB = 3;
    localparam int unsigned CHK_SL = 4;
    localparam int unsigned CHK_PN = 5;
    localparam int unsigned NUM_CHK = 6;

    // ==========================================================
    // control criterion bit positions in the enable mask
    localparam int unsigned NUM_CRIT = 29;
    localparam int unsigned CRIT_FIXED_DA = 0;
    localparam int unsigned CRIT_PREFIX_DA = 1;
    localparam int unsigned CRIT_RANGE_DA = 2;
    localparam int unsigned CRIT_DA0 = 3;
    localparam int unsigned CRIT_ET0 = 11;
    localparam int unsigned CRIT_PAIR8 = 19;
    localparam int unsigned CRIT_ET10 = 21;
    localparam int unsigned NUM_SINGLE_DA = 8;
    localparam int unsigned NUM_SINGLE_ET = 16;
    localparam int unsigned NUM_PAIR = 2;
    localparam int unsigned NUM_ET_SEL = 18;
    localparam int unsigned PAIR_BASE_NUM = 8;

    // ==========================================================
    // reset values
    localparam logic [47:0] FIXED_DA_RESET = 48'h01000CCCCCCC;
    localparam logic [43:0] PREFIX_DA_RESET = 44'h0180C200000;

    typedef enum logic [1:0] {
        FSC_UNTAGGED,
        FSC_TAGGED,
        FSC_BAD_TAG,
        FSC_KEY_TAG
    } fsc_tag_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_ETYPE,
        ST_VTCI,
        ST_SECTAG,
        ST_SKIP
    } fsc_st_t;

    typedef struct packed {
        fsc_st_t st;
        logic [3:0] cnt;
        logic [2:0] idx;
        logic [47:0] da;
        logic [15:0] et_first;
        logic have_first;
        logic [15:0] et_cur;
        logic [1:0] nvlan;
        logic first_is_stag;
        logic [15:0] vt0;
        logic [15:0] vt1;
        logic sec_seen;
        logic sec_done;
        logic [7:0] tci;
        logic [7:0] sl;
        logic [31:0] pn;
        logic [47:0] fixed_da;
        logic [43:0] prefix_da;
        logic res_valid;
        logic res_ctl;
        fsc_tag_t res_tag;
        logic res_vlan_valid;
        logic res_stag;
        logic res_qtag;
        logic res_qinq;
        logic [2:0] res_up;
        logic [11:0] res_vid;
        logic [2:0] res_inner_up;
        logic [11:0] res_inner_vid;
        logic [15:0] res_etype;
    } fsc_state_t;

endpackage

// [core/fsc_classifier.sv]
`timescale 1ns/1ps

module fsc_classifier (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // frame byte stream
    input wire logic frame_valid_in,
    input wire logic frame_sop_in,
    input wire logic frame_eop_in,
    input wire logic [7:0] frame_byte_in,
    // control classification settings
    input wire logic fixed_dest_addr_wr_in,
    input wire logic [47:0] fixed_dest_addr_criterion_in,
    input wire logic dest_addr_prefix_wr_in,
    input wire logic [43:0] dest_addr_prefix_criterion_in,
    input wire logic [47:0] dest_range_low_bound_in,
    input wire logic [47:0] dest_range_high_bound_in,
    input wire logic [7:0][47:0] single_dest_addr_criterion_in,
    input wire logic [15:0][15:0] single_ethertype_criterion_in,
    input wire logic [1:0][47:0] paired_addr_criterion_in,
    input wire logic [1:0][15:0] paired_type_criterion_in,
    input wire logic [17:0] ethertype_source_select_in,
    input wire logic [28:0] criterion_enable_mask_in,
    // tag and vlan parse settings
    input wire logic [5:0] tag_check_settings_in,
    input wire logic vlan_tag_bypass_in,
    input wire logic [15:0] vlan_ctag_type_in,
    input wire logic [15:0] vlan_stag_type_in,
    input wire logic priority_enable_in,
    input wire logic [2:0] default_priority_in,
    input wire logic [7:0][2:0] priority_remap_outer_in,
    input wire logic [7:0][2:0] priority_remap_inner_in,
    // classification results
    output logic result_valid_out,
    output logic control_out,
    output fsc_pkg::fsc_tag_t tag_status_out,
    output logic vlan_valid_out,
    output logic stag_valid_out,
    output logic qtag_valid_out,
    output logic qinq_found_out,
    output logic [2:0] outer_priority_out,
    output logic [11:0] outer_vid_out,
    output logic [2:0] inner_priority_out,
    output logic [11:0] inner_vid_out,
    output logic [15:0] parsed_etype_out,
    output logic [47:0] fixed_dest_addr_out,
    output logic [43:0] dest_addr_prefix_out
);
    import fsc_pkg::*;

    fsc_state_t s_q;
    fsc_state_t s_d;

    // ==========================================================
    // next state
    always_comb begin
        logic [NUM_CRIT-1:0] hit;
        logic [15:0] etv;
        logic [15:0] et_pick;
        logic [NUM_CHK-1:0] fault;
        logic is_vtag;
        int unsigned num;
        hit = '0;
        etv = {s_q.et_cur[15:8], frame_byte_in};
        et_pick = '0;
        fault = '0;
        is_vtag = 1'b0;
        num = 0;
        s_d = s_q;
        s_d.res_valid = 1'b0;

        // software rewrites of the reset-loaded compare values
        if (fixed_dest_addr_wr_in) begin
            s_d.fixed_da = fixed_dest_addr_criterion_in;
        end
        if (dest_addr_prefix_wr_in) begin
            s_d.prefix_da = dest_addr_prefix_criterion_in;
        end

        if (frame_valid_in) begin
            if (frame_sop_in) begin
                // a one-byte frame is a link status frame and leaves no trace
                s_d.st = frame_eop_in ? ST_IDLE : ST_HDR;
                s_d.da = {40'h0, frame_byte_in};
                s_d.cnt = 4'h1;
                s_d.idx = 3'h0;
                s_d.nvlan = 2'h0;
                s_d.have_first = 1'b0;
                s_d.first_is_stag = 1'b0;
                s_d.sec_seen = 1'b0;
                s_d.sec_done = 1'b0;
                s_d.et_cur = 16'h0;
                s_d.et_first = 16'h0;
            end else begin
                unique case (s_q.st)
                    ST_IDLE: begin
                        s_d.st = ST_IDLE;
                    end
                    ST_HDR: begin
                        if (s_q.cnt < 4'(DA_BYTES)) begin
                            s_d.da = {s_q.da[39:0], frame_byte_in};
                        end
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt == HDR_LAST) begin
                            s_d.st = ST_ETYPE;
                            s_d.idx = 3'h0;
                        end
                    end
                    ST_ETYPE: begin
                        if (s_q.idx == 3'h0) begin
                            s_d.et_cur[15:8] = frame_byte_in;
                            s_d.idx = 3'h1;
                        end else begin
                            s_d.et_cur = etv;
                            s_d.idx = 3'h0;
                            if (!s_q.have_first) begin
                                s_d.et_first = etv;
                                s_d.have_first = 1'b1;
                            end
                            is_vtag = (etv == vlan_ctag_type_in) || (etv == vlan_stag_type_in);
                            if (is_vtag && s_q.nvlan != 2'h2) begin
                                // at most two tags are walked; a third ends the walk
                                s_d.st = ST_VTCI;
                                s_d.nvlan = s_q.nvlan + 2'h1;
                                if (s_q.nvlan == 2'h0) begin
                                    s_d.first_is_stag = (etv == vlan_stag_type_in);
                                end
                            end else if (etv == SECTAG_ETYPE && (s_q.nvlan == 2'h0 || vlan_tag_bypass_in)) begin
                                s_d.st = ST_SECTAG;
                                s_d.sec_seen = 1'b1;
                            end else begin
                                s_d.st = ST_SKIP;
                            end
                        end
                    end
                    ST_VTCI: begin
                        if (s_q.idx == 3'h0) begin
                            if (s_q.nvlan == 2'h1) begin
                                s_d.vt0[15:8] = frame_byte_in;
                            end else begin
                                s_d.vt1[15:8] = frame_byte_in;
                            end
                            s_d.idx = 3'h1;
                        end else begin
                            if (s_q.nvlan == 2'h1) begin
                                s_d.vt0[7:0] = frame_byte_in;
                            end else begin
                                s_d.vt1[7:0] = frame_byte_in;
                            end
                            s_d.idx = 3'h0;
                            s_d.st = ST_ETYPE;
                        end
                    end
                    ST_SECTAG: begin
                        unique case (s_q.idx)
                            3'h0: s_d.tci = frame_byte_in;
                            3'h1: s_d.sl = frame_byte_in;
                            default: s_d.pn = {s_q.pn[23:0], frame_byte_in};
                        endcase
                        s_d.idx = s_q.idx + 3'h1;
                        if (s_q.idx == SECTAG_LAST) begin
                            s_d.sec_done = 1'b1;
                            s_d.st = ST_SKIP;
                        end
                    end
                    ST_SKIP: begin
                        s_d.st = ST_SKIP;
                    end
                endcase
            end

            // ==================================================
            // frame end: all three results latched in one step
            if (frame_eop_in && !frame_sop_in && s_q.st != ST_IDLE) begin
                s_d.st = ST_IDLE;
                s_d.res_valid = 1'b1;

                // control classification
                hit[CRIT_FIXED_DA] = (s_d.da == s_d.fixed_da);
                hit[CRIT_PREFIX_DA] = (s_d.da[47:4] == s_d.prefix_da);
                hit[CRIT_RANGE_DA] = (s_d.da >= dest_range_low_bound_in) &&
                                     (s_d.da <= dest_range_high_bound_in);
                for (int i = 0; i < NUM_SINGLE_DA; i++) begin
                    hit[CRIT_DA0 + i] = (s_d.da == single_dest_addr_criterion_in[i]);
                end
                for (int j = 0; j < NUM_SINGLE_ET; j++) begin
                    // criterion numbers skip 8 and 9, which belong to the pairs
                    num = (j < 8) ? j : j + NUM_PAIR;
                    et_pick = ethertype_source_select_in[num] ? s_d.et_cur : s_d.et_first;
                    if (j < 8) begin
                        hit[CRIT_ET0 + j] = (et_pick == single_ethertype_criterion_in[j]);
                    end else begin
                        hit[CRIT_ET10 + j - 8] = (et_pick == single_ethertype_criterion_in[j]);
                    end
                end
                for (int k = 0; k < NUM_PAIR; k++) begin
                    et_pick = ethertype_source_select_in[PAIR_BASE_NUM + k] ? s_d.et_cur : s_d.et_first;
                    hit[CRIT_PAIR8 + k] = (s_d.da == paired_addr_criterion_in[k]) &&
                                          (et_pick == paired_type_criterion_in[k]);
                end
                // key-agreement frames reach the control path only via a programmed criterion
                s_d.res_ctl = |(hit & criterion_enable_mask_in);

                // security tag status
                fault[CHK_V] = s_d.tci[TCI_V];
                fault[CHK_CE] = s_d.tci[TCI_C] && !s_d.tci[TCI_E];
                fault[CHK_SCES] = s_d.tci[TCI_SC] && s_d.tci[TCI_ES];
                fault[CHK_SCB] = s_d.tci[TCI_SC] && s_d.tci[TCI_SCB];
                fault[CHK_SL] = (s_d.sl >= SL_LIMIT);
                fault[CHK_PN] = (s_d.pn == 32'h0);
                fault = fault & tag_check_settings_in;
                if (!s_d.sec_seen) begin
                    s_d.res_tag = FSC_UNTAGGED;
                end else if (!s_d.sec_done) begin
                    // a tag cut short by the frame end cannot be trusted
                    s_d.res_tag = FSC_BAD_TAG;
                end else if (fault[CHK_V] || fault[CHK_CE]) begin
                    s_d.res_tag = FSC_BAD_TAG;
                end else if (!s_d.tci[TCI_C] && s_d.tci[TCI_E]) begin
                    // reported apart so flow lookup can only bypass it
                    s_d.res_tag = FSC_KEY_TAG;
                end else if (|fault) begin
                    s_d.res_tag = FSC_BAD_TAG;
                end else begin
                    s_d.res_tag = FSC_TAGGED;
                end

                // vlan results
                s_d.res_vlan_valid = (s_d.nvlan != 2'h0);
                s_d.res_stag = (s_d.nvlan != 2'h0) && s_d.first_is_stag;
                s_d.res_qtag = (s_d.nvlan != 2'h0) && !s_d.first_is_stag;
                s_d.res_qinq = (s_d.nvlan == 2'h2);
                if (s_d.nvlan != 2'h0 && priority_enable_in) begin
                    s_d.res_up = priority_remap_outer_in[s_d.vt0[15:13]];
                end else begin
                    s_d.res_up = default_priority_in;
                end
                s_d.res_vid = s_d.vt0[11:0];
                s_d.res_inner_up = priority_remap_inner_in[s_d.vt1[15:13]];
                s_d.res_inner_vid = s_d.vt1[11:0];
                s_d.res_etype = s_d.et_cur;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.res_tag <= FSC_UNTAGGED;
            s_q.fixed_da <= FIXED_DA_RESET;
            s_q.prefix_da <= PREFIX_DA_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs, all straight from registers
    assign result_valid_out = s_q.res_valid;
    assign control_out = s_q.res_ctl;
    assign tag_status_out = s_q.res_tag;
    assign vlan_valid_out = s_q.res_vlan_valid;
    assign stag_valid_out = s_q.res_stag;
    assign qtag_valid_out = s_q.res_qtag;
    assign qinq_found_out = s_q.res_qinq;
    assign outer_priority_out = s_q.res_up;
    assign outer_vid_out = s_q.res_vid;
    assign inner_priority_out = s_q.res_inner_up;
    assign inner_vid_out = s_q.res_inner_vid;
    assign parsed_etype_out = s_q.res_etype;
    assign fixed_dest_addr_out = s_q.fixed_da;
    assign dest_addr_prefix_out = s_q.prefix_da;

endmodule

// [tb/fsc_classifier_properties.sv]
`timescale 1ns/1ps
module fsc_classifier_chk
    import fsc_pkg::*;
(
    // clock, reset and inputs
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic frame_valid_in,
    input wire logic frame_sop_in,
    input wire logic frame_eop_in,
    input wire logic fixed_dest_addr_wr_in,
    input wire logic [47:0] fixed_dest_addr_criterion_in,
    input wire logic dest_addr_prefix_wr_in,
    input wire logic [47:0] dest_range_low_bound_in,
    input wire logic [47:0] dest_range_high_bound_in,
    input wire logic [28:0] criterion_enable_mask_in,
    input wire logic priority_enable_in,
    input wire logic [2:0] default_priority_in,
    // outputs
    input wire logic result_valid_out,
    input wire logic control_out,
    input wire fsc_pkg::fsc_tag_t tag_status_out,
    input wire logic vlan_valid_out,
    input wire logic stag_valid_out,
    input wire logic qtag_valid_out,
    input wire logic qinq_found_out,
    input wire logic [2:0] outer_priority_out,
    input wire logic [15:0] parsed_etype_out,
    input wire logic [47:0] fixed_dest_addr_out,
    input wire logic [43:0] dest_addr_prefix_out
);
    // ==========================================================
    // frame tracking; status frames (sop with eop) leave it alone
    logic open_q;
    logic eop_take;
    assign eop_take = frame_valid_in && frame_eop_in && !frame_sop_in && open_q;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            open_q <= 1'b0;
        end else if (frame_valid_in && (frame_sop_in != frame_eop_in)) begin
            open_q <= frame_sop_in;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_result_after_eop: assert property (eop_take |=> result_valid_out)
        else $error("no result after frame end");
    a_result_cause: assert property (result_valid_out |-> $past(eop_take))
        else $error("result without frame end");
    a_result_pulse: assert property (result_valid_out |=> !result_valid_out)
        else $error("result pulse too long");
    a_results_hold: assert property (!result_valid_out |->
        $stable({control_out, tag_status_out, vlan_valid_out, outer_priority_out, parsed_etype_out}))
        else $error("results moved between frames");
    a_all_disabled: assert property (result_valid_out && $past(criterion_enable_mask_in) == '0
        |-> !control_out) else $error("control with all criteria off");
    a_full_range: assert property (result_valid_out && $past(criterion_enable_mask_in[2])
        && $past(dest_range_low_bound_in) == '0 && (&$past(dest_range_high_bound_in)) |-> control_out)
        else $error("full range missed");
    a_fixed_da_load: assert property (fixed_dest_addr_wr_in
        |=> fixed_dest_addr_out == $past(fixed_dest_addr_criterion_in)) else $error("address not loaded");
    a_prefix_hold: assert property (!dest_addr_prefix_wr_in |=> $stable(dest_addr_prefix_out))
        else $error("prefix changed without write");
    a_vlan_flags: assert property (result_valid_out && !vlan_valid_out
        |-> !stag_valid_out && !qtag_valid_out && !qinq_found_out) else $error("tag flag without vlan");
    a_default_prio: assert property (result_valid_out && (!vlan_valid_out || !$past(priority_enable_in))
        |-> outer_priority_out == $past(default_priority_in)) else $error("default priority wrong");
endmodule

bind fsc_classifier fsc_classifier_chk chk (.ref_clk_in, .sys_rst_in, .frame_valid_in, .frame_sop_in,
    .frame_eop_in, .fixed_dest_addr_wr_in, .fixed_dest_addr_criterion_in, .dest_addr_prefix_wr_in,
    .dest_range_low_bound_in, .dest_range_high_bound_in, .criterion_enable_mask_in, .priority_enable_in,
    .default_priority_in, .result_valid_out, .control_out, .tag_status_out, .vlan_valid_out,
    .stag_valid_out, .qtag_valid_out, .qinq_found_out, .outer_priority_out, .parsed_etype_out,
    .fixed_dest_addr_out, .dest_addr_prefix_out);

// [tb/fsc_mac_model.sv]
`timescale 1ns/1ps
module fsc_mac_model (
    // clock
    input wire logic clk_in,
    // byte stream toward the classifier
    output logic valid_out,
    output logic sop_out,
    output logic eop_out,
    output logic [7:0] byte_out
);
    // ==========================================================
    // frame sender; idle cycles invert the byte so stale data never looks valid
    initial begin
        valid_out = 1'b0;
        sop_out = 1'b0;
        eop_out = 1'b0;
        byte_out = 8'h00;
    end
    task automatic send(input logic [7:0] b[$], input int gap);
        for (int i = 0; i < b.size(); i++) begin
            for (int g = 0; g < gap && i > 0; g++) begin
                @(posedge clk_in);
                #1;
                valid_out = 1'b0;
                byte_out = ~byte_out;
            end
            @(posedge clk_in);
            #1;
            valid_out = 1'b1;
            sop_out = (i == 0);
            eop_out = (i == b.size() - 1);
            byte_out = b[i];
        end
        @(posedge clk_in);
        #1;
        valid_out = 1'b0;
        sop_out = 1'b0;
        eop_out = 1'b0;
        byte_out = ~byte_out;
    endtask
endmodule

// [tb/fsc_classifier_tb_top.sv]
`timescale 1ns/1ps
module fsc_classifier_tb_top;
    import fsc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic frame_valid_in, frame_sop_in, frame_eop_in;
    logic [7:0] frame_byte_in;
    logic fixed_dest_addr_wr_in = 0, dest_addr_prefix_wr_in = 0, vlan_tag_bypass_in = 0, priority_enable_in = 1;
    logic [47:0] fixed_dest_addr_criterion_in = '0;
    logic [47:0] dest_range_low_bound_in = 48'h020000000100, dest_range_high_bound_in = 48'h020000000100;
    logic [43:0] dest_addr_prefix_criterion_in = '0;
    logic [7:0][47:0] single_dest_addr_criterion_in = '0;
    logic [15:0][15:0] single_ethertype_criterion_in = '0;
    logic [1:0][47:0] paired_addr_criterion_in = {48'h0, 48'h020000000008};
    logic [1:0][15:0] paired_type_criterion_in = {16'h0, 16'h1234};
    logic [17:0] ethertype_source_select_in = '0;
    logic [28:0] criterion_enable_mask_in = '0;
    logic [5:0] tag_check_settings_in = 6'h3F;
    logic [15:0] vlan_ctag_type_in = 16'h9100, vlan_stag_type_in = 16'h88A8;
    logic [2:0] default_priority_in = 3'h5;
    logic [7:0][2:0] priority_remap_outer_in, priority_remap_inner_in;
    logic result_valid_out, control_out, vlan_valid_out, stag_valid_out, qtag_valid_out, qinq_found_out;
    fsc_tag_t tag_status_out;
    logic [2:0] outer_priority_out, inner_priority_out;
    logic [11:0] outer_vid_out, inner_vid_out;
    logic [15:0] parsed_etype_out;
    logic [47:0] fixed_dest_addr_out;
    logic [43:0] dest_addr_prefix_out;
    int mismatches = 0, compares = 0, got = 0, cycles = 0;
    logic [7:0] frm[$];
    // {mask, dest, ethertype, control}
    localparam logic [93:0] CTL_T [13] = '{{29'h0, 48'h01000CCCCCCC, 16'h0800, 1'b0},
        {29'h1, 48'h01000CCCCCCC, 16'h0800, 1'b1}, {29'h1, 48'h01000CCCCCCD, 16'h0800, 1'b0},
        {29'h2, 48'h0180C200000E, 16'h0800, 1'b1}, {29'h2, 48'h0180C200001E, 16'h0800, 1'b0},
        {29'h4, 48'h020000000100, 16'h0800, 1'b1}, {29'h4, 48'h020000000101, 16'h0800, 1'b0},
        {29'h40, 48'h020000000003, 16'h0800, 1'b1}, {29'h840, 48'h020000000004, 16'h888E, 1'b1},
        {29'h840, 48'h020000000004, 16'h0800, 1'b0}, {29'h200000, 48'h020000000004, 16'h88CC, 1'b1},
        {29'h80000, 48'h020000000008, 16'h0800, 1'b0}, {29'h80000, 48'h020000000008, 16'h1234, 1'b1}};
    // {status, control byte, short length, packet number}
    localparam logic [49:0] SEC_T [9] = '{{FSC_TAGGED, 8'h0C, 8'h00, 32'h1}, {FSC_BAD_TAG, 8'h8C, 8'h00, 32'h1},
        {FSC_BAD_TAG, 8'h04, 8'h00, 32'h1}, {FSC_KEY_TAG, 8'h08, 8'h00, 32'h1}, {FSC_BAD_TAG, 8'h6C, 8'h00, 32'h1},
        {FSC_BAD_TAG, 8'h3C, 8'h00, 32'h1}, {FSC_BAD_TAG, 8'h0C, 8'h30, 32'h1}, {FSC_TAGGED, 8'h0C, 8'h2F, 32'h1},
        {FSC_BAD_TAG, 8'h0C, 8'h00, 32'h0}};

    fsc_classifier dut (.*);
    fsc_mac_model mac (.clk_in(ref_clk_in), .valid_out(frame_valid_in), .sop_out(frame_sop_in),
        .eop_out(frame_eop_in), .byte_out(frame_byte_in));

    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (result_valid_out === 1'b1) got++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ==========================================================
    // helpers
    task chk(input string what, input logic [47:0] exp, input logic [47:0] act);
        compares++;
        if (act !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask
    task put48(input logic [47:0] v);
        for (int i = 5; i >= 0; i--) frm.push_back(v[i*8 +: 8]);
    endtask
    task put16(input logic [15:0] v);
        frm.push_back(v[15:8]);
        frm.push_back(v[7:0]);
    endtask
    task hdr(input logic [47:0] da);
        frm.delete();
        put48(da);
        put48(48'h0A0B0C0D0E0F);
    endtask
    task run(input int exp_n, input int gap);
        int n;
        n = got;
        mac.send(frm, gap);
        @(posedge ref_clk_in);
        #1;
        chk("results", exp_n, got - n);
    endtask
    task give_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task t_ctl();
        for (int i = 0; i < 13; i++) begin
            criterion_enable_mask_in = CTL_T[i][93:65];
            hdr(CTL_T[i][64:17]);
            put16(CTL_T[i][16:1]);
            run(1, 0);
            chk("control", CTL_T[i][0], control_out);
            chk("tag", FSC_UNTAGGED, tag_status_out);
        end
    endtask
    task t_write();
        fixed_dest_addr_criterion_in = 48'h020000000077;
        dest_addr_prefix_criterion_in = 44'h0180C200001;
        fixed_dest_addr_wr_in = 1'b1;
        dest_addr_prefix_wr_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        fixed_dest_addr_wr_in = 1'b0;
        dest_addr_prefix_wr_in = 1'b0;
        chk("fixed_da", 48'h020000000077, fixed_dest_addr_out);
        chk("prefix", 44'h0180C200001, dest_addr_prefix_out);
        for (int m = 0; m < 3; m++) begin
            criterion_enable_mask_in = 29'(1 << m);
            dest_range_low_bound_in = '0;
            dest_range_high_bound_in = '1;
            hdr(m == 1 ? 48'h0180C200001A : 48'h020000000077);
            put16(16'h0800);
            run(1, 0);
            chk("control", 1'b1, control_out);
        end
        criterion_enable_mask_in = 29'h1000;
        for (int s = 0; s < 2; s++) begin
            ethertype_source_select_in = 18'(s << 1);
            hdr(48'h020000000004);
            put16(16'h9100);
            put16(16'h0001);
            put16(16'h0806);
            run(1, 0);
            chk("control", s, control_out);
        end
        criterion_enable_mask_in = '0;
    endtask
    task t_sectag();
        for (int i = 0; i < 12; i++) begin
            vlan_tag_bypass_in = (i == 10);
            tag_check_settings_in = {i < 11, 5'h1F};
            hdr(48'h020000000004);
            if (i inside {9, 10}) put32(32'h91000001);
            put16(SECTAG_ETYPE);
            put16(i > 8 ? 16'h0C00 : SEC_T[i][47:32]);
            put32(i > 8 ? 32'(i < 11) : SEC_T[i][31:0]);
            run(1, 0);
            chk("tag", i < 9 ? SEC_T[i][49:48] : (i == 9 ? FSC_UNTAGGED : FSC_TAGGED), tag_status_out);
        end
    endtask
    task put32(input logic [31:0] v);
        put16(v[31:16]);
        put16(v[15:0]);
    endtask
    task t_vlan();
        hdr(48'h020000000004);
        put32(32'h91008ABC);
        put16(16'h0806);
        run(1, 0);
        chk("vlan", 4'b1010, {vlan_valid_out, stag_valid_out, qtag_valid_out, qinq_found_out});
        chk("prio", 3'h3, outer_priority_out);
        chk("vid", 12'hABC, outer_vid_out);
        chk("etype", 16'h0806, parsed_etype_out);
        priority_enable_in = 1'b0;
        run(1, 2);
        chk("prio", 3'h5, outer_priority_out);
        priority_enable_in = 1'b1;
        hdr(48'h020000000004);
        put32(32'h88A8C123);
        put32(32'h91004456);
        put16(16'h0800);
        run(1, 1);
        chk("vlan", 4'b1101, {vlan_valid_out, stag_valid_out, qtag_valid_out, qinq_found_out});
        chk("prio", 3'h1, outer_priority_out);
        chk("inner", {3'h3, 12'h456}, {inner_priority_out, inner_vid_out});
        chk("etype", 16'h0800, parsed_etype_out);
        frm = '{8'h01};
        run(0, 0);
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            priority_remap_outer_in[i] = 3'(7 - i);
            priority_remap_inner_in[i] = 3'(i ^ 1);
        end
        single_dest_addr_criterion_in[3] = 48'h020000000003;
        single_ethertype_criterion_in[0] = PORT_AUTH_ETYPE;
        single_ethertype_criterion_in[1] = 16'h0806;
        single_ethertype_criterion_in[8] = 16'h88CC;
        repeat (4) @(posedge ref_clk_in);
        #1;
        sys_rst_in = 1'b0;
        chk("fixed_da", FIXED_DA_RESET, fixed_dest_addr_out);
        chk("prefix", PREFIX_DA_RESET, dest_addr_prefix_out);
        t_ctl();
        t_sectag();
        t_vlan();
        t_write();
        give_verdict();
    end
endmodule
